// File: ccw_defs.vh
// Register offsets, field positions, reset values and timing constants of the clock control watchdog
`ifndef CCW_DEFS_VH
`define CCW_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCW_OFS_FREQ_SELECT 8'h05
`define CCW_OFS_IDENT 8'h06
`define CCW_OFS_RESERVED 8'h07
`define CCW_OFS_WDG_TIMEOUT 8'h08
`define CCW_OFS_DRIVE_RESET_WDG 8'h09
`define CCW_OFS_SKEW_FIXED 8'h0a

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCW_FREQUENCY_SOURCE_OVERRIDE_BIT 2
`define CCW_MID_SEL_BIT 1
`define CCW_USB_SEL_BIT 0
`define CCW_TICK_SEL_BIT 0
`define CCW_USB_DRV_BIT 7
`define CCW_PERIPH_DRV_BIT 6
`define CCW_MID_DRV_BIT 5
`define CCW_RST_EXPIRY_BIT 4
`define CCW_RST_RETUNE_BIT 3
`define CCW_EXPIRED_BIT 2
`define CCW_WDG_EN_BIT 1
`define CCW_FIXED_MODE_BIT 4

// ----------------------------------------
// Reset values and identity
// ----------------------------------------
`define CCW_WDG_COUNT_RESET 5'h1f
`define CCW_REVISION_CODE 4'h0
// Arbitrary maker code
`define CCW_MAKER_CODE 4'h5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCW_CLK_KHZ 20000
`define CCW_SHORT_TICK_MS 150
`define CCW_LONG_TICK_MS 2500
`define CCW_SHORT_TICK_CYCLES (`CCW_SHORT_TICK_MS * `CCW_CLK_KHZ)
`define CCW_LONG_TICK_CYCLES (`CCW_LONG_TICK_MS * `CCW_CLK_KHZ)
`define CCW_RESET_PULSE_CYCLES 8'h10
`define CCW_STRAP_SETTLE_CYCLES 2'h3

`endif

// File: ccw_clock_config_watchdog.v
// Control bytes and watchdog of a clock synthesizer behind a two-wire management bus
`timescale 1ns/1ps
// Overview of operation
// - Override 0 takes frequency from strap inputs; 1 takes it from soft frequency code.
// - Mid select picks 48 or 66 MHz; USB select picks 24 or 48 MHz.
// - Identification byte holds revision in bits 7..4, read-only maker code in 3..0.
// - Five-bit count holds timeout in ticks; short tick gives 150 ms to 4.65 s.
// - Tick select 0 gives 150 ms tick, 1 gives 2.5 s tick.
// - Count reaching zero sets expired flag, and resets if expiry reset enabled.
// - Expiry reset enable 1 produces a reset pulse per timeout; 0 produces none.
// - Retune reset enable 1 produces a reset pulse after each frequency change.
// - Expired flag reads 1 after timeout; host writes 1 to clear, 0 ignored.
// - Clearing watchdog enable stops the timer and reloads the programmed count.
// - Enabled watchdog starts counting only after an output frequency change.
// - Timeout brings a reset if expiry reset enabled, loads recovery frequency and locks recovery mode.
// - In recovery mode, writes that would change output frequency are ignored.
// - Host clears watchdog enable to leave recovery mode and unlock writes.
// - Three drive bits select normal or high drive for their output groups.
// - Three-bit processor skew selects one of eight documented skew settings.
// - Fixed divider mode pins mid outputs at 64 MHz, peripheral at 32 MHz.
// - Strap inputs are latched from pins and read back in the upper bits.
// - Recovery source 0 uses latched straps, 1 uses programmed recovery dividers.
`include "ccw_defs.vh"

module ccw_clock_config_watchdog #(
   parameter [31:0] SHORT_TICK_CYCLES = `CCW_SHORT_TICK_CYCLES,
   parameter [31:0] LONG_TICK_CYCLES = `CCW_LONG_TICK_CYCLES
) (
   input wire clk,
   input wire resetn,
   input wire link_clk,
   input wire link_wr,
   input wire [7:0] link_addr,
   input wire [7:0] link_wdata,
   output reg [7:0] link_rdata,
   input wire [4:0] strap_frequency_inputs,
   input wire [4:0] soft_frequency_code,
   input wire recovery_source_select,
   output reg [4:0] active_freq_code,
   output reg recovery_divider_in_use,
   output reg recovery_mode,
   output reg system_reset_pulse,
   output reg mid_clock_output_select,
   output reg usb_clock_rate_select,
   output reg usb_clock_drive,
   output reg peripheral_clock_drive,
   output reg mid_clock_drive,
   output reg [2:0] processor_clock_skew,
   output reg fixed_divider_mode
);

   // ----------------------------------------
   // Link synchronisers
   // ----------------------------------------
   reg [16:0] link_meta;
   reg [16:0] link_sync;
   reg link_clk_last;
   reg [4:0] strap_meta;
   reg [4:0] strap_sync;
   wire link_clk_s = link_sync[16];
   wire link_wr_s = link_sync[15];
   wire [7:0] addr_s = link_sync[14:7];
   reg link_meta_hold;
   reg link_sync_hold;

   // The bus engine holds address and data stable around the rising link edge
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link_meta <= 17'h00000;
         link_sync <= 17'h00000;
         link_meta_hold <= 1'b0;
         link_sync_hold <= 1'b0;
         link_clk_last <= 1'b0;
         strap_meta <= 5'h00;
         strap_sync <= 5'h00;
      end else begin
         link_meta <= {link_clk, link_wr, link_addr, link_wdata[7:1]};
         link_sync <= link_meta;
         link_meta_hold <= link_wdata[0];
         link_sync_hold <= link_meta_hold;
         link_clk_last <= link_clk_s;
         strap_meta <= strap_frequency_inputs;
         strap_sync <= strap_meta;
      end
   end

   // Address and data ride the same two stages as the link clock, so the byte is whole when the edge is seen
   wire wr_strobe = link_clk_s & ~link_clk_last & link_wr_s;

   // ----------------------------------------
   // Strap latch
   // ----------------------------------------
   reg [1:0] settle_cnt;
   reg [4:0] strap_latched;

   // Straps are caught once, after the synchroniser has filled
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         settle_cnt <= 2'h0;
         strap_latched <= 5'h00;
      end else if (settle_cnt != `CCW_STRAP_SETTLE_CYCLES) begin
         settle_cnt <= settle_cnt + 2'h1;
         if (settle_cnt == (`CCW_STRAP_SETTLE_CYCLES - 2'h1)) begin
            strap_latched <= strap_sync;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   reg freq_override;
   reg [4:0] wdg_count_field;
   reg tick_select;
   reg reset_on_expiry_enable;
   reg reset_on_retune_enable;
   reg watchdog_enable;
   reg watchdog_expired_flag;
   reg [4:0] wdg_count;
   reg wdg_running;
   reg [31:0] tick_cnt;
   reg [7:0] pulse_cnt;
   reg expire;
   wire freq_change;

   wire wr_freq = wr_strobe & (addr_s == `CCW_OFS_FREQ_SELECT);
   wire wr_timeout = wr_strobe & (addr_s == `CCW_OFS_WDG_TIMEOUT);
   wire wr_drive = wr_strobe & (addr_s == `CCW_OFS_DRIVE_RESET_WDG);
   wire wr_skew = wr_strobe & (addr_s == `CCW_OFS_SKEW_FIXED);
   wire [7:0] wdata_full = {link_sync[6:0], link_sync_hold};

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         freq_override <= 1'b0;
         mid_clock_output_select <= 1'b0;
         usb_clock_rate_select <= 1'b0;
         wdg_count_field <= `CCW_WDG_COUNT_RESET;
         tick_select <= 1'b0;
         processor_clock_skew <= 3'h0;
         fixed_divider_mode <= 1'b0;
      end else begin
         // Frequency-changing bits stay frozen while locked
         if (wr_freq && !recovery_mode) begin
            freq_override <= wdata_full[`CCW_FREQUENCY_SOURCE_OVERRIDE_BIT];
            mid_clock_output_select <= wdata_full[`CCW_MID_SEL_BIT];
            usb_clock_rate_select <= wdata_full[`CCW_USB_SEL_BIT];
         end
         if (wr_timeout) begin
            wdg_count_field <= wdata_full[5:1];
            tick_select <= wdata_full[`CCW_TICK_SEL_BIT];
         end
         if (wr_skew) begin
            processor_clock_skew <= wdata_full[7:5];
            if (!recovery_mode) begin
               fixed_divider_mode <= wdata_full[`CCW_FIXED_MODE_BIT];
            end
         end
      end
   end

   // ----------------------------------------
   // Drive and watchdog control byte
   // ----------------------------------------
   // The expiry flag of this byte lives with the watchdog, where set and clear meet
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         usb_clock_drive <= 1'b0;
         peripheral_clock_drive <= 1'b0;
         mid_clock_drive <= 1'b0;
         reset_on_expiry_enable <= 1'b0;
         reset_on_retune_enable <= 1'b0;
         watchdog_enable <= 1'b0;
      end else begin
         if (wr_drive) begin
            usb_clock_drive <= wdata_full[`CCW_USB_DRV_BIT];
            peripheral_clock_drive <= wdata_full[`CCW_PERIPH_DRV_BIT];
            mid_clock_drive <= wdata_full[`CCW_MID_DRV_BIT];
            reset_on_expiry_enable <= wdata_full[`CCW_RST_EXPIRY_BIT];
            reset_on_retune_enable <= wdata_full[`CCW_RST_RETUNE_BIT];
            watchdog_enable <= wdata_full[`CCW_WDG_EN_BIT];
         end
      end
   end

   // ----------------------------------------
   // Effective frequency
   // ----------------------------------------
   reg [4:0] next_freq_code;

   always @* begin
      if (recovery_mode) begin
         next_freq_code = strap_latched;
      end else if (freq_override) begin
         next_freq_code = soft_frequency_code;
      end else begin
         next_freq_code = strap_latched;
      end
   end

   reg mid_sel_last;
   reg usb_sel_last;
   reg fixed_last;
   reg settled;

   // Nothing counts as a retune until the straps have settled, else the first latch would start the watchdog
   assign freq_change = settled & ((next_freq_code != active_freq_code) | (mid_clock_output_select != mid_sel_last)
      | (usb_clock_rate_select != usb_sel_last) | (fixed_divider_mode != fixed_last)
      | (expire & recovery_source_select));

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         active_freq_code <= 5'h00;
         mid_sel_last <= 1'b0;
         usb_sel_last <= 1'b0;
         fixed_last <= 1'b0;
         settled <= 1'b0;
         recovery_divider_in_use <= 1'b0;
      end else begin
         active_freq_code <= next_freq_code;
         mid_sel_last <= mid_clock_output_select;
         usb_sel_last <= usb_clock_rate_select;
         fixed_last <= fixed_divider_mode;
         settled <= (settle_cnt == `CCW_STRAP_SETTLE_CYCLES);
         if (expire) begin
            recovery_divider_in_use <= recovery_source_select;
         end else if (!watchdog_enable) begin
            recovery_divider_in_use <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   // Tick lengths are parameters so a bench can shorten them; the defaults give the 150 ms and 2.5 s ticks
   wire [31:0] tick_len = tick_select ? LONG_TICK_CYCLES : SHORT_TICK_CYCLES;
   wire tick = wdg_running & (tick_cnt >= tick_len - 32'h1);

   always @* begin
      expire = tick & (wdg_count <= 5'h01);
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdg_count <= `CCW_WDG_COUNT_RESET;
         wdg_running <= 1'b0;
         tick_cnt <= 32'h0;
         recovery_mode <= 1'b0;
         watchdog_expired_flag <= 1'b0;
      end else begin
         // After a timeout the counter reloads the programmed count and stays stopped until the host drops the enable
         if (!watchdog_enable) begin
            wdg_running <= 1'b0;
            wdg_count <= wdg_count_field;
            tick_cnt <= 32'h0;
            recovery_mode <= 1'b0;
         end else if (expire) begin
            wdg_running <= 1'b0;
            wdg_count <= 5'h00;
            tick_cnt <= 32'h0;
            recovery_mode <= 1'b1;
         end else if (!wdg_running) begin
            tick_cnt <= 32'h0;
            wdg_count <= wdg_count_field;
            if (freq_change && !recovery_mode) begin
               wdg_running <= 1'b1;
            end
         end else if (tick) begin
            tick_cnt <= 32'h0;
            wdg_count <= wdg_count - 5'h01;
         end else begin
            tick_cnt <= tick_cnt + 32'h1;
         end
         // A timeout in the same cycle as the host clear keeps the flag set
         if (expire) begin
            watchdog_expired_flag <= 1'b1;
         end else if (wr_drive && wdata_full[`CCW_EXPIRED_BIT]) begin
            watchdog_expired_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Reset pulse
   // ----------------------------------------
   // A fresh trigger restarts the full width instead of stacking a second pulse
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pulse_cnt <= 8'h00;
         system_reset_pulse <= 1'b0;
      end else begin
         if ((expire && reset_on_expiry_enable) || (freq_change && reset_on_retune_enable)) begin
            pulse_cnt <= `CCW_RESET_PULSE_CYCLES;
         end else if (pulse_cnt != 8'h00) begin
            pulse_cnt <= pulse_cnt - 8'h01;
         end
         system_reset_pulse <= (pulse_cnt != 8'h00);
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Read data follows the synchronised address, so a host sees it three clocks after moving the address
   reg [7:0] next_rdata;

   always @* begin
      next_rdata = 8'h00;
      case (addr_s)
         `CCW_OFS_FREQ_SELECT: begin
            next_rdata = {strap_latched, freq_override, mid_clock_output_select, usb_clock_rate_select};
         end
         `CCW_OFS_IDENT: begin
            next_rdata = {`CCW_REVISION_CODE, `CCW_MAKER_CODE};
         end
         `CCW_OFS_WDG_TIMEOUT: begin
            next_rdata = {2'b00, wdg_count_field, tick_select};
         end
         `CCW_OFS_DRIVE_RESET_WDG: begin
            next_rdata = {usb_clock_drive, peripheral_clock_drive, mid_clock_drive, reset_on_expiry_enable,
               reset_on_retune_enable, watchdog_expired_flag, watchdog_enable, 1'b0};
         end
         `CCW_OFS_SKEW_FIXED: begin
            next_rdata = {processor_clock_skew, fixed_divider_mode, 4'h0};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link_rdata <= 8'h00;
      end else begin
         link_rdata <= next_rdata;
      end
   end

endmodule // ccw_clock_config_watchdog

// File: ccw_checker_assertions.sv
// Checker of read-back, reset pulse and recovery lock of the watchdog block
`timescale 1ns/1ps
`include "ccw_defs.vh"
module ccw_checker (
   input wire clk,
   input wire resetn,
   input wire [7:0] link_addr,
   input wire [7:0] link_rdata,
   input wire [4:0] strap_frequency_inputs,
   input wire [4:0] soft_frequency_code,
   input wire recovery_source_select,
   input wire [4:0] active_freq_code,
   input wire recovery_divider_in_use,
   input wire recovery_mode,
   input wire system_reset_pulse,
   input wire mid_clock_output_select,
   input wire usb_clock_rate_select,
   input wire usb_clock_drive,
   input wire peripheral_clock_drive,
   input wire mid_clock_drive,
   input wire [2:0] processor_clock_skew,
   input wire fixed_divider_mode
);
   // Straps are latched a few cycles after reset, so strap checks wait
   reg [3:0] settle;
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         settle <= 4'h0;
      else if (settle != 4'hf)
         settle <= settle + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_ident_read: assert property (
      (link_addr == `CCW_OFS_IDENT) [*5] |-> link_rdata == {`CCW_REVISION_CODE, `CCW_MAKER_CODE})
      else $error("identification byte wrong");
   a_rsvd_read: assert property (
      (link_addr == `CCW_OFS_RESERVED) [*5] |-> link_rdata == 8'h00) else $error("reserved byte not zero");
   a_timeout_rsvd: assert property (
      (link_addr == `CCW_OFS_WDG_TIMEOUT) [*5] |-> link_rdata[7:6] == 2'h0) else $error("timeout byte top bits set");
   a_strap_read: assert property (
      (link_addr == `CCW_OFS_FREQ_SELECT && settle == 4'hf) [*5] |-> link_rdata[7:3] == strap_frequency_inputs)
      else $error("latched straps wrong");
   a_drive_read: assert property (
      (link_addr == `CCW_OFS_DRIVE_RESET_WDG && $stable({usb_clock_drive, peripheral_clock_drive, mid_clock_drive})) [*5]
      |-> link_rdata[7:5] == {usb_clock_drive, peripheral_clock_drive, mid_clock_drive} && !link_rdata[0])
      else $error("drive bits differ from outputs");
   a_skew_read: assert property (
      (link_addr == `CCW_OFS_SKEW_FIXED && $stable({processor_clock_skew, fixed_divider_mode})) [*5]
      |-> link_rdata[7:4] == {processor_clock_skew, fixed_divider_mode}) else $error("skew byte differs from outputs");
   a_pulse_width: assert property (
      $rose(system_reset_pulse) |-> system_reset_pulse [*8] ##1 system_reset_pulse [*8] ##1 !system_reset_pulse)
      else $error("reset pulse width wrong");
   a_recovery_lock: assert property (
      recovery_mode && $past(recovery_mode) && $past(recovery_mode, 2) |-> $stable(active_freq_code)
      && $stable(fixed_divider_mode) && $stable(mid_clock_output_select)) else $error("frequency moved while locked");
   a_recovery_src: assert property (
      $rose(recovery_mode) |-> ##[0:2] recovery_divider_in_use == recovery_source_select
      && (recovery_source_select || active_freq_code == strap_frequency_inputs)) else $error("recovery source wrong");
   a_code_source: assert property (
      settle == 4'hf && !recovery_divider_in_use && $stable(soft_frequency_code)
      |-> active_freq_code == strap_frequency_inputs || active_freq_code == soft_frequency_code)
      else $error("frequency code from no source");
endmodule // ccw_checker

bind ccw_clock_config_watchdog ccw_checker u_chk (.clk, .resetn, .link_addr, .link_rdata, .strap_frequency_inputs,
   .soft_frequency_code, .recovery_source_select, .active_freq_code, .recovery_divider_in_use, .recovery_mode,
   .system_reset_pulse, .mid_clock_output_select, .usb_clock_rate_select, .usb_clock_drive,
   .peripheral_clock_drive, .mid_clock_drive, .processor_clock_skew, .fixed_divider_mode);

// File: ccw_host_model.sv
// Management bus host stand-in that writes and reads the control bytes
`timescale 1ns/1ps
module ccw_host_model (
   input wire clk,
   output reg link_clk,
   output reg link_wr,
   output reg [7:0] link_addr,
   output reg [7:0] link_wdata,
   input wire [7:0] link_rdata
);
   initial begin
      link_clk = 1'b0;
      link_wr = 1'b0;
      link_addr = 8'h00;
      link_wdata = 8'h00;
   end
   // Link clock stands still between transfers; released data is inverted so a stale byte never looks valid
   task automatic write_byte(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         link_addr <= a;
         link_wdata <= d;
         link_wr <= 1'b1;
         repeat (4) @(posedge clk);
         link_clk <= 1'b1;
         repeat (4) @(posedge clk);
         link_clk <= 1'b0;
         repeat (4) @(posedge clk);
         link_wr <= 1'b0;
         link_wdata <= ~d;
      end
   endtask
   task automatic read_byte(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk);
         link_addr <= a;
         repeat (5) @(posedge clk);
         d = link_rdata;
      end
   endtask
endmodule // ccw_host_model

// File: tb.sv
// Testbench of the clock control watchdog through byte writes and reads
`timescale 1ns/1ps
`include "ccw_defs.vh"
module tb;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg [4:0] strap_frequency_inputs = 5'h13;
   reg [4:0] soft_frequency_code = 5'h0b;
   reg recovery_source_select = 1'b0;
   wire link_clk, link_wr, recovery_divider_in_use, recovery_mode, system_reset_pulse, mid_clock_output_select;
   wire usb_clock_rate_select, usb_clock_drive, peripheral_clock_drive, mid_clock_drive, fixed_divider_mode;
   wire [7:0] link_addr, link_wdata, link_rdata;
   wire [4:0] active_freq_code;
   wire [2:0] processor_clock_skew;
   integer num_errors = 0;
   integer n_compared = 0;
   integer pulses = 0;
   integer p0, n, i;
   reg [7:0] rd;
   always #25 clk = ~clk;
   always @(posedge system_reset_pulse) pulses = pulses + 1;
   ccw_host_model u_host (.clk, .link_clk, .link_wr, .link_addr, .link_wdata, .link_rdata);
   // Short ticks keep the watchdog runs brief
   ccw_clock_config_watchdog #(.SHORT_TICK_CYCLES(10), .LONG_TICK_CYCLES(40)) u_dut (.clk, .resetn, .link_clk,
      .link_wr, .link_addr, .link_wdata, .link_rdata, .strap_frequency_inputs, .soft_frequency_code,
      .recovery_source_select, .active_freq_code, .recovery_divider_in_use, .recovery_mode, .system_reset_pulse,
      .mid_clock_output_select, .usb_clock_rate_select, .usb_clock_drive, .peripheral_clock_drive,
      .mid_clock_drive, .processor_clock_skew, .fixed_divider_mode);
   task automatic check(input string what, input [7:0] exp, input [7:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task automatic rchk(input [7:0] a, input [7:0] exp, input [7:0] mask);
      begin
         u_host.read_byte(a, rd);
         check("read data", exp, rd & mask);
      end
   endtask
   task automatic wait_recov;
      begin
         n = 0;
         while (recovery_mode !== 1'b1 && n < 400) begin
            @(posedge clk);
            n = n + 1;
         end
         // Let the pulse and code launched around the timeout settle before they are compared
         repeat (2) @(posedge clk);
      end
   endtask
   task report_and_stop;
      begin
         if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      num_errors = num_errors + 1;
      report_and_stop;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(posedge clk);
      rchk(8'h08, 8'h3e, 8'hff);
      rchk(8'h05, {5'h13, 3'h0}, 8'hff);
      u_host.write_byte(8'h06, 8'hff);
      u_host.write_byte(8'h07, 8'hff);
      u_host.write_byte(8'h20, 8'hff);
      u_host.write_byte(8'h08, 8'hff);
      rchk(8'h06, {`CCW_REVISION_CODE, `CCW_MAKER_CODE}, 8'hff);
      rchk(8'h07, 8'h00, 8'hff);
      rchk(8'h20, 8'h00, 8'hff);
      rchk(8'h08, 8'h3f, 8'hff);
      u_host.write_byte(8'h09, 8'he1);
      rchk(8'h09, 8'he0, 8'hff);
      check("drive", 8'h07, {5'h0, usb_clock_drive, peripheral_clock_drive, mid_clock_drive});
      for (i = 0; i < 8; i++) begin
         u_host.write_byte(8'h0a, {i[2:0], i[0], 4'h0});
         check("skew", {4'h0, i[2:0], i[0]}, {4'h0, processor_clock_skew, fixed_divider_mode});
      end
      u_host.write_byte(8'h05, 8'h07);
      check("code", {3'h0, soft_frequency_code}, {3'h0, active_freq_code});
      check("selects", 8'h03, {6'h0, mid_clock_output_select, usb_clock_rate_select});
      rchk(8'h05, {5'h13, 3'h7}, 8'hff);
      u_host.write_byte(8'h05, 8'h00);
      check("code", 8'h13, {3'h0, active_freq_code});
      check("pulses", 8'h00, 8'(pulses));
      u_host.write_byte(8'h09, 8'h08);
      u_host.write_byte(8'h05, 8'h04);
      repeat (20) @(posedge clk);
      check("pulses", 8'h01, 8'(pulses));
      u_host.write_byte(8'h08, 8'h04);
      u_host.write_byte(8'h09, 8'h12);
      p0 = pulses;
      u_host.write_byte(8'h05, 8'h07);
      wait_recov;
      check("expiry time", 8'h01, {7'h0, n >= 8 && n <= 22});
      check("pulses", 8'h01, 8'(pulses - p0));
      rchk(8'h09, 8'h16, 8'hff);
      check("code", 8'h13, {3'h0, active_freq_code});
      u_host.write_byte(8'h05, 8'h00);
      u_host.write_byte(8'h0a, 8'h00);
      check("fixed", 8'h01, {7'h0, fixed_divider_mode});
      rchk(8'h05, 8'h07, 8'h07);
      u_host.write_byte(8'h09, 8'h12);
      rchk(8'h09, 8'h16, 8'hff);
      u_host.write_byte(8'h09, 8'h04);
      rchk(8'h09, 8'h00, 8'hff);
      u_host.write_byte(8'h05, 8'h00);
      check("selects", 8'h00, {5'h0, mid_clock_output_select, usb_clock_rate_select, recovery_mode});
      recovery_source_select <= 1'b1;
      u_host.write_byte(8'h08, 8'h03);
      u_host.write_byte(8'h09, 8'h02);
      p0 = pulses;
      u_host.write_byte(8'h05, 8'h03);
      wait_recov;
      check("expiry time", 8'h01, {7'h0, n >= 26 && n <= 44});
      check("pulses", 8'h00, 8'(pulses - p0));
      check("divider", 8'h01, {7'h0, recovery_divider_in_use});
      u_host.write_byte(8'h09, 8'h04);
      u_host.write_byte(8'h08, 8'h05);
      u_host.write_byte(8'h09, 8'h02);
      u_host.write_byte(8'h05, 8'h00);
      u_host.write_byte(8'h09, 8'h00);
      u_host.write_byte(8'h09, 8'h02);
      repeat (200) @(posedge clk);
      check("recovery", 8'h00, {7'h0, recovery_mode});
      rchk(8'h08, 8'h05, 8'hff);
      report_and_stop;
   end
endmodule // tb
